// ---- core/wcn_notify.sv ----
// window comparator, event flags, notification pin and register slave
// How it works
// [RULE1] rms flag drives pin while set if its enable bit is set
// [RULE2] input crc error flag drives pin while set if its enable bit is set
// [RULE3] reserved bits of source enable and pin config read as zero
// [RULE4] drive bit 0 gives open-drain pin, 1 push-pull; resets to 0
// [RULE5] signalling field 0 pulses once per raised flag, 1 holds level
// [RULE6] summary register shows per channel whether an event was detected
// [RULE7] summary bit clears when upper and lower flags of channel clear
// [RULE8] upper flag sets above upper limit or digital 1; write 1 clears
// [RULE9] lower flag sets below lower limit or digital 0; write 1 clears
// [RULE10] region 0 flags outside the window; digital 1 flags
// [RULE11] region 1 flags inside the window; digital 0 flags
// [RULE12] channel 0 upper low nibble sits in margin bits 7-4, reset 1111
// [RULE13] margin nibble shifted left three gives hysteresis on both limits; code applies it in region 0 only, region 1 releases without it
// [RULE14] upper msb register holds the top eight bits of upper limit
// [RULE15] count n needs n+1 consecutive samples beyond limit to flag
// [RULE16] only channels selected in notify select reach the pin
// [RULE17] pin condition is OR of enabled sources; pulse per new flag
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module wcn_notify #(
   parameter int NUM_CH = 8
) (
   input  wire logic                  clock_in,
   input  wire logic                  rst_in,
   input  wire wcn_pkg::wcn_bus_type  bus_in,
   output logic [7:0]                 rdata_out,
   input  wire wcn_pkg::wcn_sample_type sample_in,
   input  wire logic [NUM_CH-1:0]     digital_mode_in,
   input  wire logic [NUM_CH-1:0]     digital_level_in,
   input  wire logic                  rms_complete_flag_in,
   input  wire logic                  crc_error_in,
   output logic                       notify_pin_out,
   output logic                       notify_pin_oe_out,
   output logic                       irq_out
);
   if (NUM_CH != wcn_pkg::CH_COUNT) begin : g_check
      $error("wcn_notify serves exactly eight channels");
   end

   wcn_pkg::wcn_state_type s_q;
   wcn_pkg::wcn_state_type s_d;

   logic [wcn_pkg::RES_W-1:0] upper_th;
   logic [wcn_pkg::RES_W-1:0] lower_th;
   logic [wcn_pkg::RES_W-1:0] hyst;
   logic [wcn_pkg::RES_W-1:0] upper_rel;
   logic [wcn_pkg::RES_W:0]   lower_sum;
   logic [wcn_pkg::RES_W-1:0] lower_rel;
   logic [3:0]                need;
   logic [7:0]                summary;

   // limits of the comparator
   assign upper_th  = {s_q.upper_msb, s_q.margin[7:4]};   // [RULE12] [RULE14]
   assign lower_th  = {s_q.lower_msb, s_q.low_count[7:4]};
   assign hyst      = {5'h00, s_q.margin[3:0], 3'h0};     // [RULE13]
   assign upper_rel = (upper_th > hyst) ? upper_th - hyst : 12'h000;   // [RULE13]
   assign lower_sum = {1'b0, lower_th} + {1'b0, hyst};
   assign lower_rel = lower_sum[wcn_pkg::RES_W] ? 12'hFFF : lower_sum[wcn_pkg::RES_W-1:0];
   assign need      = s_q.low_count[3:0];
   assign summary   = s_q.upper_flg | s_q.lower_flg;       // [RULE6] [RULE7]

   always_comb begin
      logic [7:0]                up_set;
      logic [7:0]                lo_set;
      logic [7:0]                up_clr;
      logic [7:0]                lo_clr;
      logic [1:0]                aux_clr;
      logic [3:0]                int_ev;
      logic [3:0]                int_clr;
      logic                      hc;
      logic                      lc;
      logic [wcn_pkg::RES_W-1:0] res;
      logic [17:0]               src;
      logic                      level;
      logic                      pulse;
      logic                      assert_pin;
      up_set     = 8'h00;
      lo_set     = 8'h00;
      up_clr     = 8'h00;
      lo_clr     = 8'h00;
      aux_clr    = 2'h0;
      int_clr    = 4'h0;
      hc         = 1'b0;
      lc         = 1'b0;
      res        = sample_in.result;
      int_ev     = 4'h0;
      src        = 18'h0;
      level      = 1'b0;
      pulse      = 1'b0;
      assert_pin = 1'b0;
      s_d        = s_q;
      s_d.rdata  = 8'h00;

      // digital levels pass two flip-flops
      s_d.lvl_meta = digital_level_in;
      s_d.lvl_sync = s_q.lvl_meta;

      // register writes
      if (bus_in.wr) begin
         case (bus_in.addr)
            wcn_pkg::ADDR_CH_SEL:    s_d.ch_sel    = bus_in.wdata;
            wcn_pkg::ADDR_SRC_EN:    s_d.src_en    = bus_in.wdata & wcn_pkg::SRC_EN_MASK;  // [RULE3]
            wcn_pkg::ADDR_PIN_CFG:   s_d.pin_cfg   = bus_in.wdata & wcn_pkg::PIN_CFG_MASK; // [RULE3]
            wcn_pkg::ADDR_UPPER_FLG: up_clr        = bus_in.wdata;   // [RULE8] [RULE7]
            wcn_pkg::ADDR_LOWER_FLG: lo_clr        = bus_in.wdata;   // [RULE9] [RULE7]
            wcn_pkg::ADDR_REGION:    s_d.region    = bus_in.wdata;
            wcn_pkg::ADDR_MARGIN:    s_d.margin    = bus_in.wdata;
            wcn_pkg::ADDR_UPPER_MSB: s_d.upper_msb = bus_in.wdata;
            wcn_pkg::ADDR_LOW_COUNT: s_d.low_count = bus_in.wdata;
            wcn_pkg::ADDR_LOWER_MSB: s_d.lower_msb = bus_in.wdata;
            wcn_pkg::ADDR_AUX_FLG:   aux_clr       = bus_in.wdata[1:0];
            wcn_pkg::ADDR_INT_CLR:   int_clr       = bus_in.wdata[3:0];
            wcn_pkg::ADDR_INT_EN:    s_d.int_en    = bus_in.wdata[3:0];
            default: ;
         endcase
      end

      // register reads, data in the next cycle
      if (bus_in.rd) begin
         case (bus_in.addr)
            wcn_pkg::ADDR_CH_SEL:    s_d.rdata = s_q.ch_sel;
            wcn_pkg::ADDR_SRC_EN:    s_d.rdata = s_q.src_en & wcn_pkg::SRC_EN_MASK;   // [RULE3]
            wcn_pkg::ADDR_PIN_CFG:   s_d.rdata = s_q.pin_cfg & wcn_pkg::PIN_CFG_MASK; // [RULE3]
            wcn_pkg::ADDR_SUMMARY:   s_d.rdata = summary;                             // [RULE6]
            wcn_pkg::ADDR_UPPER_FLG: s_d.rdata = s_q.upper_flg;
            wcn_pkg::ADDR_LOWER_FLG: s_d.rdata = s_q.lower_flg;
            wcn_pkg::ADDR_REGION:    s_d.rdata = s_q.region;
            wcn_pkg::ADDR_MARGIN:    s_d.rdata = s_q.margin;
            wcn_pkg::ADDR_UPPER_MSB: s_d.rdata = s_q.upper_msb;
            wcn_pkg::ADDR_LOW_COUNT: s_d.rdata = s_q.low_count;
            wcn_pkg::ADDR_LOWER_MSB: s_d.rdata = s_q.lower_msb;
            wcn_pkg::ADDR_AUX_FLG:   s_d.rdata = {6'h00, s_q.aux_flg};
            wcn_pkg::ADDR_INT_STAT:  s_d.rdata = {4'h0, s_q.int_stat};
            wcn_pkg::ADDR_INT_EN:    s_d.rdata = {4'h0, s_q.int_en};
            default:                 s_d.rdata = 8'h00;
         endcase
      end

      // per channel comparison
      for (int i = 0; i < wcn_pkg::CH_COUNT; i++) begin
         if (digital_mode_in[i]) begin
            s_d.up_cnt[i] = 4'h0;
            s_d.lo_cnt[i] = 4'h0;
            s_d.up_act[i] = 1'b0;
            s_d.lo_act[i] = 1'b0;
            if (!s_q.region[i]) begin
               up_set[i] = s_q.lvl_sync[i];          // [RULE8] [RULE10]
            end else begin
               lo_set[i] = ~s_q.lvl_sync[i];         // [RULE9] [RULE11]
            end
         end else if (sample_in.valid && sample_in.channel == 3'(i)) begin
            if (!s_q.region[i]) begin
               hc = res > upper_th;                  // [RULE8] [RULE10]
               lc = res < lower_th;                  // [RULE9] [RULE10]
            end else begin
               hc = 1'b0;
               lc = (res > lower_th) && (res < upper_th);   // [RULE11]
            end
            // upper side
            if (hc) begin
               if (s_q.up_cnt[i] >= need) begin      // [RULE15]
                  if (!s_q.up_act[i]) begin
                     up_set[i] = 1'b1;
                  end
                  s_d.up_act[i] = 1'b1;
               end else begin
                  s_d.up_cnt[i] = s_q.up_cnt[i] + 4'h1;
               end
            end else begin
               s_d.up_cnt[i] = 4'h0;
               if (res < upper_rel) begin            // [RULE13]
                  s_d.up_act[i] = 1'b0;
               end
            end
            // lower side
            if (lc) begin
               if (s_q.lo_cnt[i] >= need) begin      // [RULE15]
                  if (!s_q.lo_act[i]) begin
                     lo_set[i] = 1'b1;
                  end
                  s_d.lo_act[i] = 1'b1;
               end else begin
                  s_d.lo_cnt[i] = s_q.lo_cnt[i] + 4'h1;
               end
            end else begin
               s_d.lo_cnt[i] = 4'h0;
               if (s_q.region[i] || res > lower_rel) begin   // [RULE13]
                  s_d.lo_act[i] = 1'b0;
               end
            end
         end
      end

      // sticky flags, a set beats a clear in the same cycle
      s_d.upper_flg = (s_q.upper_flg & ~up_clr) | up_set;   // [RULE8]
      s_d.lower_flg = (s_q.lower_flg & ~lo_clr) | lo_set;   // [RULE9]
      s_d.aux_flg[wcn_pkg::AUX_CRC_BIT] = (s_q.aux_flg[wcn_pkg::AUX_CRC_BIT]
                                           & ~aux_clr[wcn_pkg::AUX_CRC_BIT]) | crc_error_in;
      s_d.aux_flg[wcn_pkg::AUX_RMS_BIT] = (s_q.aux_flg[wcn_pkg::AUX_RMS_BIT]
                                           & ~aux_clr[wcn_pkg::AUX_RMS_BIT]) | rms_complete_flag_in;

      // interrupt status
      int_ev[wcn_pkg::INT_UPPER_BIT] = |up_set;
      int_ev[wcn_pkg::INT_LOWER_BIT] = |lo_set;
      int_ev[wcn_pkg::INT_RMS_BIT]   = rms_complete_flag_in;
      int_ev[wcn_pkg::INT_CRC_BIT]   = crc_error_in;
      s_d.int_stat = (s_q.int_stat & ~int_clr) | int_ev;

      // notification sources
      src = {s_q.upper_flg & s_q.ch_sel,                                        // [RULE16]
             s_q.lower_flg & s_q.ch_sel,                                        // [RULE16]
             s_q.aux_flg[wcn_pkg::AUX_RMS_BIT] & s_q.src_en[wcn_pkg::SRC_RMS_BIT],  // [RULE1]
             s_q.aux_flg[wcn_pkg::AUX_CRC_BIT] & s_q.src_en[wcn_pkg::SRC_CRC_BIT]}; // [RULE2]
      s_d.src_prev = src;
      level = |src;                                 // [RULE17]
      pulse = |(src & ~s_q.src_prev);               // [RULE17]
      assert_pin = s_q.pin_cfg[wcn_pkg::PIN_LEVEL_BIT] ? level : pulse;   // [RULE5]
      s_d.pin_level = assert_pin;
      if (s_q.pin_cfg[wcn_pkg::PIN_DRV_BIT]) begin
         s_d.pin_oe = 1'b1;                         // [RULE4]
      end else begin
         s_d.pin_oe = ~assert_pin;                  // [RULE4]
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         s_q           <= '0;
         s_q.margin    <= wcn_pkg::RST_MARGIN;      // [RULE12]
         s_q.upper_msb <= wcn_pkg::RST_UPPER;
         s_q.pin_oe    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_out         = s_q.rdata;
   assign notify_pin_out    = s_q.pin_level & s_q.pin_cfg[wcn_pkg::PIN_DRV_BIT];   // [RULE4]
   assign notify_pin_oe_out = s_q.pin_oe;
   assign irq_out           = |(s_q.int_stat & s_q.int_en);
endmodule : wcn_notify

// ---- core/wcn_pkg.sv ----
// package: register map, field layout, reset values and carrier types of the window notifier
package wcn_pkg;
   localparam int CH_COUNT = 8;
   localparam int RES_W    = 12;

   localparam logic [7:0] ADDR_CH_SEL    = 8'h14;
   localparam logic [7:0] ADDR_SRC_EN    = 8'h16;
   localparam logic [7:0] ADDR_PIN_CFG   = 8'h17;
   localparam logic [7:0] ADDR_SUMMARY   = 8'h18;
   localparam logic [7:0] ADDR_UPPER_FLG = 8'h1A;
   localparam logic [7:0] ADDR_LOWER_FLG = 8'h1C;
   localparam logic [7:0] ADDR_REGION    = 8'h1E;
   localparam logic [7:0] ADDR_MARGIN    = 8'h20;
   localparam logic [7:0] ADDR_UPPER_MSB = 8'h21;
   localparam logic [7:0] ADDR_LOW_COUNT = 8'h22;
   localparam logic [7:0] ADDR_LOWER_MSB = 8'h23;
   localparam logic [7:0] ADDR_AUX_FLG   = 8'h30;
   localparam logic [7:0] ADDR_INT_STAT  = 8'h31;
   localparam logic [7:0] ADDR_INT_CLR   = 8'h32;
   localparam logic [7:0] ADDR_INT_EN    = 8'h33;

   localparam int SRC_CRC_BIT   = 0;
   localparam int SRC_RMS_BIT   = 1;
   localparam int PIN_DRV_BIT   = 2;
   localparam int PIN_LEVEL_BIT = 0;
   localparam int AUX_CRC_BIT   = 0;
   localparam int AUX_RMS_BIT   = 1;
   localparam int INT_UPPER_BIT = 0;
   localparam int INT_LOWER_BIT = 1;
   localparam int INT_RMS_BIT   = 2;
   localparam int INT_CRC_BIT   = 3;

   localparam logic [7:0] SRC_EN_MASK  = 8'h03;
   localparam logic [7:0] PIN_CFG_MASK = 8'h07;
   localparam logic [7:0] INT_MASK     = 8'h0F;
   localparam logic [7:0] RST_ZERO     = 8'h00;
   localparam logic [7:0] RST_MARGIN   = 8'hF0;
   localparam logic [7:0] RST_UPPER    = 8'hFF;

   typedef struct packed {
      logic             valid;
      logic [2:0]       channel;
      logic [RES_W-1:0] result;
   } wcn_sample_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } wcn_bus_type;

   typedef struct packed {
      logic [7:0]                ch_sel;
      logic [7:0]                src_en;
      logic [7:0]                pin_cfg;
      logic [7:0]                upper_flg;
      logic [7:0]                lower_flg;
      logic [7:0]                region;
      logic [7:0]                margin;
      logic [7:0]                upper_msb;
      logic [7:0]                low_count;
      logic [7:0]                lower_msb;
      logic [1:0]                aux_flg;
      logic [3:0]                int_stat;
      logic [3:0]                int_en;
      logic [CH_COUNT-1:0][3:0]  up_cnt;
      logic [CH_COUNT-1:0][3:0]  lo_cnt;
      logic [CH_COUNT-1:0]       up_act;
      logic [CH_COUNT-1:0]       lo_act;
      logic [CH_COUNT-1:0]       lvl_meta;
      logic [CH_COUNT-1:0]       lvl_sync;
      logic [17:0]               src_prev;
      logic                      pin_level;
      logic                      pin_oe;
      logic [7:0]                rdata;
   } wcn_state_type;
endpackage : wcn_pkg

// ---- dv/test_window_compare_notify.sv ----
// testbench: window notifier against a behavioural register and flag model
`timescale 1ns/1ps
module test_window_compare_notify;
   logic                    clock_in = 1'b0;
   logic                    rst_in   = 1'b1;
   wcn_pkg::wcn_bus_type    bus      = '0;
   wcn_pkg::wcn_sample_type smp_s    = '0;
   logic [7:0]              mode     = 8'h00;
   logic [7:0]              lvl      = 8'h00;
   logic                    rms      = 1'b0;
   logic                    crc      = 1'b0;
   logic [7:0]              rdata_out;
   logic                    notify_pin_out;
   logic                    notify_pin_oe_out;
   logic                    irq_out;
   logic                    pw;
   logic [7:0]              m [256];
   int                      cnt [8];
   bit                      ua [8];
   int                      error_cnt = 0;
   int                      n_checks  = 0;
   logic [7:0] ra [12] = '{8'h14, 8'h16, 8'h17, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h21,
                           8'h22, 8'h23, 8'h40};
   logic [7:0] pc [6]  = '{8'h05, 8'h01, 8'h00, 8'h04, 8'h03, 8'h06};
   always #2 clock_in = ~clock_in;
   wcn_notify #(.NUM_CH(8)) dut (
      .clock_in(clock_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata_out),
      .sample_in(smp_s), .digital_mode_in(mode), .digital_level_in(lvl),
      .rms_complete_flag_in(rms), .crc_error_in(crc), .notify_pin_out(notify_pin_out),
      .notify_pin_oe_out(notify_pin_oe_out), .irq_out(irq_out));
   wcn_pin_pullup pu (.pin_in(notify_pin_out), .oe_in(notify_pin_oe_out), .wire_out(pw));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic cmp_bit(input logic got, input logic exp);
      cmp({7'h00, got}, {7'h00, exp});
   endtask : cmp_bit
   task automatic report_and_stop;
      if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock_in);
      bus.wr <= 1'b0;
      case (a)
         8'h1A, 8'h1C: m[a] = m[a] & ~d;
         8'h32: m[8'h31] = m[8'h31] & ~d;
         8'h16: m[a] = d & 8'h03;
         8'h17: m[a] = d & 8'h07;
         8'h33: m[a] = d & 8'h0F;
         8'h14, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h23: m[a] = d;
         default: ;
      endcase
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock_in);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock_in);
      bus.rd <= 1'b0;
      #1 cmp(rdata_out, (a == 8'h18) ? m[8'h1A] | m[8'h1C] : m[a]);
   endtask : rd
   task automatic smp(input logic [2:0] c, input logic [11:0] r);
      logic [11:0] u;
      logic [11:0] l;
      int          h;
      u = {m[8'h21], m[8'h20][7:4]};
      h = int'(m[8'h20][3:0]) << 3;
      l = {m[8'h23], m[8'h22][7:4]};
      @(posedge clock_in);
      smp_s <= '{1'b1, c, r};
      @(posedge clock_in);
      smp_s.valid <= 1'b0;
      if (m[8'h1E][c]) begin
         if (r > l && r < u) m[8'h1C][c] = 1'b1;
      end else begin
         cnt[c] = (r > u) ? cnt[c] + 1 : 0;
         if (cnt[c] > int'(m[8'h22][3:0]) && !ua[c]) begin
            m[8'h1A][c] = 1'b1;
            ua[c] = 1'b1;
         end
         if (int'(r) + h < int'(u)) ua[c] = 1'b0;
         if (r < l) m[8'h1C][c] = 1'b1;
      end
   endtask : smp
   task automatic ev(input int k, input logic e, input logic lm);
      @(posedge clock_in);
      if (k == 0) crc <= 1'b1;
      else rms <= 1'b1;
      @(posedge clock_in);
      crc <= 1'b0;
      rms <= 1'b0;
      @(posedge clock_in);
      #1 cmp_bit(pw, e);
      @(posedge clock_in);
      #1 cmp_bit(pw, e & lm);
      wr(8'h30, 8'h03);
      repeat (2) @(posedge clock_in);
      #1 cmp_bit(pw, 1'b0);
   endtask : ev
   initial begin
      repeat (5000) @(posedge clock_in);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      for (int i = 0; i < 256; i++) m[i] = 8'h00;
      for (int i = 0; i < 8; i++) cnt[i] = 0;
      m[8'h20] = 8'hF0;
      m[8'h21] = 8'hFF;
      void'($urandom(32'hB332));
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      foreach (ra[i]) rd(ra[i]);
      repeat (4) begin
         wr(8'h16, 8'($urandom));
         wr(8'h17, 8'($urandom));
         wr(8'h18, 8'hFF);
         rd(8'h16);
         rd(8'h17);
         rd(8'h18);
      end
      wr(8'h16, 8'h00);
      wr(8'h17, 8'h00);
      wr(8'h21, 8'h80);
      wr(8'h20, 8'h50);
      wr(8'h23, 8'h10);
      smp(0, 12'h805);
      smp(1, 12'h100);
      rd(8'h18);
      smp(0, 12'h806);
      smp(1, 12'h0FF);
      repeat (30) smp(3'($urandom % 5), 12'($urandom));
      rd(8'h1A);
      rd(8'h1C);
      m[8'h31] = {6'h00, |m[8'h1C], |m[8'h1A]};
      rd(8'h31);
      wr(8'h33, 8'h0F);
      @(posedge clock_in);
      #1 cmp_bit(irq_out, 1'b1);
      wr(8'h33, 8'h00);
      @(posedge clock_in);
      #1 cmp_bit(irq_out, 1'b0);
      wr(8'h33, 8'h0F);
      wr(8'h32, 8'h0F);
      rd(8'h31);
      #1 cmp_bit(irq_out, 1'b0);
      wr(8'h1A, 8'h0F);
      wr(8'h1C, 8'h00);
      rd(8'h1A);
      rd(8'h1C);
      rd(8'h18);
      wr(8'h1E, 8'hC0);
      smp(6, 12'h400);
      @(posedge clock_in);
      mode <= 8'h80;
      repeat (5) @(posedge clock_in);
      m[8'h1C][7] = 1'b1;
      rd(8'h1C);
      @(posedge clock_in);
      lvl <= 8'h80;
      wr(8'h1E, 8'h40);
      repeat (5) @(posedge clock_in);
      m[8'h1A][7] = 1'b1;
      rd(8'h1A);
      foreach (pc[i]) begin
         wr(8'h17, pc[i]);
         for (int k = 0; k < 2; k++) begin
            wr(8'h16, 8'(1 << k));
            ev(k, 1'b1, pc[i][0]);
         end
         wr(8'h16, 8'h00);
         for (int k = 0; k < 2; k++) ev(k, 1'b0, 1'b0);
      end
      wr(8'h17, 8'h05);
      wr(8'h14, 8'h80);
      repeat (2) @(posedge clock_in);
      #1 cmp_bit(pw, 1'b1);
      wr(8'h14, 8'h00);
      repeat (2) @(posedge clock_in);
      #1 cmp_bit(pw, 1'b0);
      wr(8'h22, 8'h02);
      repeat (2) smp(5, 12'hFFF);
      rd(8'h1A);
      smp(5, 12'hFFF);
      rd(8'h1A);
      wr(8'h22, 8'h00);
      wr(8'h20, 8'h52);
      wr(8'h1A, 8'h20);
      smp(5, 12'h7F8);
      smp(5, 12'h806);
      rd(8'h1A);
      smp(5, 12'h7F4);
      smp(5, 12'h806);
      rd(8'h1A);
      report_and_stop();
   end
endmodule : test_window_compare_notify

// ---- dv/wcn_notify_checker.sv ----
// checker: port assertions of the window notifier
`timescale 1ns/1ps
module wcn_notify_checker #(
   parameter int NUM_CH = 8
) (
   input wire logic                    clock_in,
   input wire logic                    rst_in,
   input wire wcn_pkg::wcn_bus_type    bus_in,
   input wire logic [7:0]              rdata_out,
   input wire wcn_pkg::wcn_sample_type sample_in,
   input wire logic [NUM_CH-1:0]       digital_mode_in,
   input wire logic [NUM_CH-1:0]       digital_level_in,
   input wire logic                    rms_complete_flag_in,
   input wire logic                    crc_error_in,
   input wire logic                    notify_pin_out,
   input wire logic                    notify_pin_oe_out,
   input wire logic                    irq_out
);
   logic [7:0] src_q;
   logic [7:0] cfg_q;
   logic [7:0] sel_q;
   logic       hit;
   // asserted pin level as seen on the wire
   assign hit = notify_pin_oe_out ? notify_pin_out : 1'b1;
   // shadow copies of the written configuration
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         src_q <= 8'h00;
         cfg_q <= 8'h00;
         sel_q <= 8'h00;
      end else if (bus_in.wr) begin
         if (bus_in.addr == wcn_pkg::ADDR_SRC_EN) src_q <= bus_in.wdata;
         if (bus_in.addr == wcn_pkg::ADDR_PIN_CFG) cfg_q <= bus_in.wdata;
         if (bus_in.addr == wcn_pkg::ADDR_CH_SEL) sel_q <= bus_in.wdata;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   property p_rst_idle;
      $past(rst_in) |-> notify_pin_oe_out && !notify_pin_out && !irq_out && rdata_out == 8'h00;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
   property p_rd_idle;
      !$past(bus_in.rd) |-> rdata_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_src_rsv;
      $past(bus_in.rd && bus_in.addr == wcn_pkg::ADDR_SRC_EN) |-> rdata_out[7:2] == 6'h00;
   endproperty
   a_src_rsv: assert property (p_src_rsv) else $error("source enable spare bits set");
   property p_cfg_rsv;
      $past(bus_in.rd && bus_in.addr == wcn_pkg::ADDR_PIN_CFG) |-> rdata_out[7:3] == 5'h00;
   endproperty
   a_cfg_rsv: assert property (p_cfg_rsv) else $error("pin config spare bits set");
   property p_od_low;
      !notify_pin_oe_out |-> !notify_pin_out;
   endproperty
   a_od_low: assert property (p_od_low) else $error("released pin drives high");
   property p_pp_drive;
      cfg_q[2] [*3] |-> notify_pin_oe_out;
   endproperty
   a_pp_drive: assert property (p_pp_drive) else $error("push-pull pin released");
   property p_od_quiet;
      !cfg_q[2] [*3] |-> !notify_pin_out;
   endproperty
   a_od_quiet: assert property (p_od_quiet) else $error("open-drain pin driven high");
   property p_rms_pin;
      rms_complete_flag_in && src_q[1] && cfg_q[0] |-> ##2 hit;
   endproperty
   a_rms_pin: assert property (p_rms_pin) else $error("rms completion not on pin");
   property p_crc_pin;
      crc_error_in && src_q[0] && cfg_q[0] |-> ##2 hit;
   endproperty
   a_crc_pin: assert property (p_crc_pin) else $error("crc error not on pin");
   property p_no_src;
      (sel_q == 8'h00 && src_q == 8'h00) [*4] |-> !hit;
   endproperty
   a_no_src: assert property (p_no_src) else $error("pin asserted with no source");
endmodule : wcn_notify_checker
bind wcn_notify wcn_notify_checker #(.NUM_CH(NUM_CH)) u_chk (
   .clock_in(clock_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
   .sample_in(sample_in), .digital_mode_in(digital_mode_in),
   .digital_level_in(digital_level_in), .rms_complete_flag_in(rms_complete_flag_in),
   .crc_error_in(crc_error_in), .notify_pin_out(notify_pin_out),
   .notify_pin_oe_out(notify_pin_oe_out), .irq_out(irq_out));

// ---- dv/wcn_pin_pullup.sv ----
// partner: board pull-up and receiver on the notification pin
`timescale 1ns/1ps
module wcn_pin_pullup (
   input  wire logic pin_in,
   input  wire logic oe_in,
   output wire logic wire_out
);
   // released pin floats up to the pull-up level
   assign wire_out = oe_in ? pin_in : 1'b1;
endmodule : wcn_pin_pullup
